// ==== bench/sac_alarm_assertions.sv ====
// checker: alarm output timing seen at the controller pins
// assumes the bench's short timing: 6/2 pulse, 8 cycle slow blink
`timescale 1ns/1ns
module sac_alarm_assertions #(
  parameter int AUTORESET_CYC = 200
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // pins and outputs
  input wire logic instant_loop_in,
  input wire logic delayed_loop_in,
  input wire logic panic_n,
  input wire logic pulsed_alarm_out,
  input wire logic steady_alarm_out,
  input wire logic status_led_n
);
  logic [8:0] run_r;
  logic [6:0] age_r;
  logic       seen_r;
  // age saturates so the exit-window test never wraps
  always_ff @(posedge clk)
  begin
    run_r  <= steady_alarm_out ? run_r + 9'h001 : 9'h000;
    age_r  <= reset ? 7'h00 : ((age_r == 7'h7F) ? age_r : age_r + 7'h01);
    seen_r <= reset ? 1'b0 : (seen_r | steady_alarm_out);
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  chk_pulse_gated: assert property (!steady_alarm_out |-> !pulsed_alarm_out)
    else $error("pulsed output high outside alarm");
  chk_pulse_high: assert property ($rose(pulsed_alarm_out) |->
    (pulsed_alarm_out || !steady_alarm_out) [*6]) else $error("pulse high too short");
  chk_pulse_low: assert property ($fell(pulsed_alarm_out) && steady_alarm_out |->
    !pulsed_alarm_out [*2] ##1 (pulsed_alarm_out || !steady_alarm_out))
    else $error("pulse low phase wrong");
  chk_auto_clear: assert property ($fell(steady_alarm_out) |->
    int'(run_r) == AUTORESET_CYC) else $error("alarm length wrong");
  chk_led_memory: assert property (seen_r |-> ##[1:10] $changed(status_led_n))
    else $error("led stopped blinking");
  chk_panic_fast: assert property (!panic_n [*8] |-> ##[0:4] steady_alarm_out)
    else $error("panic did not alarm");
  chk_exit_block: assert property (age_r < 7'h28 && $rose(steady_alarm_out) |->
    !$past(panic_n, 6)) else $error("alarm inside exit window");
  chk_reset_quiet: assert property ($fell(reset) |->
    !steady_alarm_out && !pulsed_alarm_out && status_led_n) else $error("outputs not idle");
endmodule // sac_alarm_assertions

bind sac_alarm sac_alarm_assertions #(.AUTORESET_CYC(AUTORESET_CYC)) i_chk (
  .clk(clk), .reset(reset), .instant_loop_in(instant_loop_in),
  .delayed_loop_in(delayed_loop_in), .panic_n(panic_n), .pulsed_alarm_out(pulsed_alarm_out),
  .steady_alarm_out(steady_alarm_out), .status_led_n(status_led_n));

// ==== bench/sac_alarm_tb.sv ====
// self-checking bench for the alarm controller with shortened timing
// assumes one 100 MHz clock and the short counts set below
`timescale 1ns/1ns
`define SAC_CHECK(nm, exp, got) \
  begin comparisons++; if ((got) !== (exp)) begin err_total++; \
  $display("wrong value %s expected %0d seen %0d", nm, exp, got); end end
module sac_alarm_tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic loop_i_open, loop_d_open, panic_press, chatter;
  wire  instant_loop_in, delayed_loop_in, panic_n;
  wire  pulsed_alarm_out, steady_alarm_out, status_led_n;
  int   err_total, comparisons, rises, flips, t, r0, f0;

  initial forever #5 clk = ~clk;
  always @(posedge steady_alarm_out) rises++;
  always @(status_led_n) flips++;

  sac_switch_model i_sw (.clk(clk), .loop_i_open(loop_i_open), .loop_d_open(loop_d_open),
    .panic_press(panic_press), .chatter(chatter), .instant_loop_in(instant_loop_in),
    .delayed_loop_in(delayed_loop_in), .panic_n(panic_n));
  sac_alarm #(.DEBOUNCE_CYC(4), .PULSE_HI_CYC(6), .PULSE_LO_CYC(2), .FAST_HALF_CYC(2),
    .DELAY_CYC(40), .AUTORESET_CYC(200)) i_dut (.clk(clk), .reset(reset),
    .instant_loop_in(instant_loop_in), .delayed_loop_in(delayed_loop_in), .panic_n(panic_n),
    .pulsed_alarm_out(pulsed_alarm_out), .steady_alarm_out(steady_alarm_out),
    .status_led_n(status_led_n));

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic conclude;
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic do_reset;
    reset = 1'b1;
    tick(4);
    reset = 1'b0;
  endtask
  // bounded wait for the steady output; t returns the cycles spent
  task automatic wait_steady(input logic lvl, input int bound);
    t = 0;
    while (steady_alarm_out !== lvl && t < bound)
    begin
      tick(1);
      t++;
    end
    `SAC_CHECK("steady_alarm_out", lvl, steady_alarm_out)
    if (steady_alarm_out !== lvl)
      conclude();
  endtask

  task automatic sc_instant;
    do_reset();
    loop_i_open = 1'b1;
    tick(300);
    `SAC_CHECK("rises in exit window", 0, rises)
    loop_i_open = 1'b0;
    chatter = 1'b1;
    tick(40);
    chatter = 1'b0;
    tick(12);
    `SAC_CHECK("rises on chatter", 0, rises)
    loop_i_open = 1'b1;
    wait_steady(1'b1, 20);
    `SAC_CHECK("instant latency ok", 1, (t >= 4 && t <= 12))
    wait_steady(1'b0, 260);
    r0 = rises;
    f0 = flips;
    tick(60);
    `SAC_CHECK("rises with loop left open", r0, rises)
    `SAC_CHECK("led memory blinking", 1, (flips - f0 >= 6))
    loop_i_open = 1'b0;
    tick(10);
    loop_i_open = 1'b1;
    wait_steady(1'b1, 20);
    loop_i_open = 1'b0;
  endtask
  task automatic sc_delayed;
    do_reset();
    tick(45);
    f0 = flips;
    loop_d_open = 1'b1;
    tick(20);
    `SAC_CHECK("fast blink in countdown", 1, (flips - f0 >= 3))
    loop_d_open = 1'b0;
    tick(8);
    loop_d_open = 1'b1;
    wait_steady(1'b1, 60);
    `SAC_CHECK("delayed latency ok", 1, (t + 28 >= 44 && t + 28 <= 54))
    loop_d_open = 1'b0;
    wait_steady(1'b0, 260);
  endtask
  task automatic sc_panic;
    do_reset();
    panic_press = 1'b1;
    wait_steady(1'b1, 20);
    `SAC_CHECK("panic latency ok", 1, (t <= 12))
    wait_steady(1'b0, 260);
    wait_steady(1'b1, 10);
    panic_press = 1'b0;
    wait_steady(1'b0, 260);
  endtask

  initial
  begin
    loop_i_open = 1'b0;
    loop_d_open = 1'b0;
    panic_press = 1'b0;
    chatter = 1'b0;
    sc_instant();
    sc_delayed();
    sc_panic();
    conclude();
  end
endmodule // sac_alarm_tb

// ==== bench/sac_switch_model.sv ====
// switch loops and panic button as the pins see them
// assumes requests change just after a rising edge
`timescale 1ns/1ns
module sac_switch_model (
  // clock
  input  wire logic clk,
  // requested switch states
  input  wire logic loop_i_open,
  input  wire logic loop_d_open,
  input  wire logic panic_press,
  input  wire logic chatter,
  // pins
  output logic      instant_loop_in,
  output logic      delayed_loop_in,
  output logic      panic_n
);
  initial {instant_loop_in, delayed_loop_in, panic_n} = 3'h1;
  // a closed chain grounds the pin, an open one lets the pull-up win
  always @(posedge clk)
  begin
    instant_loop_in <= chatter ? ~instant_loop_in : loop_i_open;
    delayed_loop_in <= loop_d_open;
    panic_n         <= ~panic_press;
  end
endmodule // sac_switch_model

// ==== common/sac_consts.vh ====
// timing constants for the security alarm controller
// assumes a 100 MHz system clock; all counts but the power-on reset count derived from times in ms
`ifndef SAC_CONSTS_VH
`define SAC_CONSTS_VH

`define SAC_CLK_HZ          100000000
// held at 64 bits so the five-minute count does not overflow 32-bit arithmetic
`define SAC_CYC_PER_MS      (64'h0000000005F5E100 / 64'h00000000000003E8)
`define SAC_DEBOUNCE_MS     500
`define SAC_PULSE_HIGH_MS   1500
`define SAC_PULSE_LOW_MS    500
`define SAC_FAST_HALF_MS    125
`define SAC_DELAY_MS        45000
`define SAC_AUTORESET_MS    300000
`define SAC_DEBOUNCE_CYC    (`SAC_DEBOUNCE_MS * `SAC_CYC_PER_MS)
`define SAC_PULSE_HIGH_CYC  (`SAC_PULSE_HIGH_MS * `SAC_CYC_PER_MS)
`define SAC_PULSE_LOW_CYC   (`SAC_PULSE_LOW_MS * `SAC_CYC_PER_MS)
`define SAC_FAST_HALF_CYC   (`SAC_FAST_HALF_MS * `SAC_CYC_PER_MS)
`define SAC_DELAY_CYC       (`SAC_DELAY_MS * `SAC_CYC_PER_MS)
`define SAC_AUTORESET_CYC   (`SAC_AUTORESET_MS * `SAC_CYC_PER_MS)
`define SAC_POR_CYC         16

`endif

// ==== rtl/sac_alarm.v ====
// security alarm controller top: loops, panic, alarm outputs and status led
// assumes one free-running clock; reset is an optional extra, the block
// makes its own power-on reset
`timescale 1ns/1ns
`include "sac_consts.vh"

module sac_alarm #(
  parameter [63:0] DEBOUNCE_CYC  = `SAC_DEBOUNCE_CYC,
  parameter [63:0] PULSE_HI_CYC  = `SAC_PULSE_HIGH_CYC,
  parameter [63:0] PULSE_LO_CYC  = `SAC_PULSE_LOW_CYC,
  parameter [63:0] FAST_HALF_CYC = `SAC_FAST_HALF_CYC,
  parameter [63:0] DELAY_CYC     = `SAC_DELAY_CYC,
  parameter [63:0] AUTORESET_CYC = `SAC_AUTORESET_CYC
) (
  // clock and optional extra reset
  input  wire clk,
  input  wire reset,
  // monitored pins, all asynchronous
  input  wire instant_loop_in,
  input  wire delayed_loop_in,
  input  wire panic_n,
  // alarm and status outputs
  output reg  pulsed_alarm_out,
  output reg  steady_alarm_out,
  output reg  status_led_n
);
  localparam ST_IDLE  = 2'b00;
  localparam ST_DELAY = 2'b01;
  localparam ST_ALARM = 2'b10;

  localparam TW = 35;

  wire por;
  wire rst;
  wire inst_open;
  wire dly_open;
  wire panic_lvl;

  reg  [1:0]    state_r;
  reg  [1:0]    state_nxt;
  reg  [TW-1:0] exit_cnt_r;
  reg           exit_done_r;
  reg  [TW-1:0] delay_cnt_r;
  reg  [TW-1:0] alarm_cnt_r;
  reg  [TW-1:0] pulse_cnt_r;
  reg  [TW-1:0] fast_cnt_r;
  reg           fast_ph_r;
  reg           memory_r;
  reg           inst_prev_r;
  reg           dly_prev_r;
  reg           inst_edge;
  reg           dly_edge;
  reg           alarm_end;
  reg           pulse_hi;

  sac_por #(
    .CYCLES (`SAC_POR_CYC)
  ) u_por (
    .clk   (clk),
    .por_r (por)
  );

  assign rst = por | reset;

  // loops idle closed (low); panic idles released (high)
  sac_debounce #(
    .CNT_W    (TW),
    .STABLE   (DEBOUNCE_CYC),
    .IDLE_LVL (1'b0)
  ) u_db_inst (
    .clk     (clk),
    .reset   (rst),
    .pin_in  (instant_loop_in),
    .level_r (inst_open)
  );

  sac_debounce #(
    .CNT_W    (TW),
    .STABLE   (DEBOUNCE_CYC),
    .IDLE_LVL (1'b0)
  ) u_db_dly (
    .clk     (clk),
    .reset   (rst),
    .pin_in  (delayed_loop_in),
    .level_r (dly_open)
  );

  sac_debounce #(
    .CNT_W    (TW),
    .STABLE   (DEBOUNCE_CYC),
    .IDLE_LVL (1'b1)
  ) u_db_panic (
    .clk     (clk),
    .reset   (rst),
    .pin_in  (panic_n),
    .level_r (panic_lvl)
  );

  // trigger on new openings only, so a loop left open cannot retrigger
  always @*
  begin
    inst_edge = inst_open & ~inst_prev_r & exit_done_r;
    dly_edge  = dly_open & ~dly_prev_r;
    alarm_end = (alarm_cnt_r == AUTORESET_CYC[TW-1:0] - 1'b1);
    // the output is registered one cycle ahead of the counter, so look one step on
    pulse_hi  = (pulse_cnt_r < PULSE_HI_CYC[TW-1:0] - 1'b1) |
                (pulse_cnt_r == PULSE_HI_CYC[TW-1:0] + PULSE_LO_CYC[TW-1:0] - 1'b1);
  end

  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
      begin
        if (~panic_lvl | inst_edge)
          state_nxt = ST_ALARM;
        else if (dly_edge)
          state_nxt = ST_DELAY;
      end
      ST_DELAY:
      begin
        // further delayed-loop openings are ignored here so the countdown is not extended
        if (~panic_lvl | inst_edge)
          state_nxt = ST_ALARM;
        else if (delay_cnt_r == DELAY_CYC[TW-1:0] - 1'b1)
          state_nxt = ST_ALARM;
      end
      ST_ALARM:
      begin
        if (alarm_end)
          state_nxt = ST_IDLE;
      end
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      state_r     <= ST_IDLE;
      exit_cnt_r  <= {TW{1'b0}};
      exit_done_r <= 1'b0;
      delay_cnt_r <= {TW{1'b0}};
      alarm_cnt_r <= {TW{1'b0}};
      pulse_cnt_r <= {TW{1'b0}};
      inst_prev_r <= 1'b0;
      dly_prev_r  <= 1'b0;
    end
    else
    begin
      state_r     <= state_nxt;
      inst_prev_r <= inst_open;
      dly_prev_r  <= dly_open;
      // exit window: instant loop disabled until this expires
      if (!exit_done_r)
      begin
        if (exit_cnt_r == DELAY_CYC[TW-1:0] - 1'b1)
          exit_done_r <= 1'b1;
        else
          exit_cnt_r <= exit_cnt_r + 1'b1;
      end
      if (state_r == ST_DELAY)
        delay_cnt_r <= delay_cnt_r + 1'b1;
      else
        delay_cnt_r <= {TW{1'b0}};
      if (state_r == ST_ALARM)
      begin
        alarm_cnt_r <= alarm_cnt_r + 1'b1;
        if (pulse_cnt_r == PULSE_HI_CYC[TW-1:0] + PULSE_LO_CYC[TW-1:0] - 1'b1)
          pulse_cnt_r <= {TW{1'b0}};
        else
          pulse_cnt_r <= pulse_cnt_r + 1'b1;
      end
      else
      begin
        alarm_cnt_r <= {TW{1'b0}};
        pulse_cnt_r <= {TW{1'b0}};
      end
    end
  end

  // led memory and blink phases; the slow phase keeps running after alarms
  // so memory blinking never stops until power-on reset or the reset input clears it
  reg [TW-1:0] slow_cnt_r;

  always @(posedge clk)
  begin
    if (rst)
    begin
      memory_r   <= 1'b0;
      fast_cnt_r <= {TW{1'b0}};
      fast_ph_r  <= 1'b0;
      slow_cnt_r <= {TW{1'b0}};
    end
    else
    begin
      if (state_r == ST_ALARM)
        memory_r <= 1'b1;
      if (fast_cnt_r == FAST_HALF_CYC[TW-1:0] - 1'b1)
      begin
        fast_cnt_r <= {TW{1'b0}};
        fast_ph_r  <= ~fast_ph_r;
      end
      else
        fast_cnt_r <= fast_cnt_r + 1'b1;
      if (slow_cnt_r == PULSE_HI_CYC[TW-1:0] + PULSE_LO_CYC[TW-1:0] - 1'b1)
        slow_cnt_r <= {TW{1'b0}};
      else
        slow_cnt_r <= slow_cnt_r + 1'b1;
    end
  end

  // outputs registered; restart after auto reset happens through IDLE
  // on the next cycle when panic is still held
  always @(posedge clk)
  begin
    if (rst)
    begin
      pulsed_alarm_out <= 1'b0;
      steady_alarm_out <= 1'b0;
      status_led_n     <= 1'b1;
    end
    else
    begin
      pulsed_alarm_out <= (state_nxt == ST_ALARM) & (state_r != ST_ALARM | pulse_hi);
      steady_alarm_out <= (state_nxt == ST_ALARM);
      if (state_r == ST_DELAY)
        status_led_n <= ~fast_ph_r;
      else if (memory_r | state_r == ST_ALARM)
        status_led_n <= ~(slow_cnt_r < PULSE_HI_CYC[TW-1:0]);
      else
        status_led_n <= 1'b1;
    end
  end
endmodule // sac_alarm

// ==== rtl/sac_debounce.v ====
// debouncer: two-flop synchroniser then a stability counter
// assumes a raw asynchronous pin; output starts at the given idle level
`timescale 1ns/1ns
module sac_debounce #(
  parameter       CNT_W    = 26,
  parameter [63:0] STABLE  = 50000000,
  parameter [0:0] IDLE_LVL = 1'b0
) (
  // clock and reset
  input  wire clk,
  input  wire reset,
  // pin and filtered level
  input  wire pin_in,
  output reg  level_r
);
  reg             sync1_r;
  reg             sync2_r;
  reg [CNT_W-1:0] cnt_r;

  always @(posedge clk)
  begin
    if (reset)
    begin
      sync1_r <= IDLE_LVL;
      sync2_r <= IDLE_LVL;
      cnt_r   <= {CNT_W{1'b0}};
      level_r <= IDLE_LVL;
    end
    else
    begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      // any bounce back to the accepted level restarts the count
      if (sync2_r == level_r)
        cnt_r <= {CNT_W{1'b0}};
      else if (cnt_r == STABLE[CNT_W-1:0] - 1'b1)
      begin
        cnt_r   <= {CNT_W{1'b0}};
        level_r <= sync2_r;
      end
      else
        cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule // sac_debounce

// ==== rtl/sac_por.v ====
// internal power-on reset: holds reset for a fixed count after configuration
// assumes registers take their declared initial values at power-up (fpga style init)
`timescale 1ns/1ns
module sac_por #(
  parameter CYCLES = 16
) (
  // clock
  input  wire clk,
  // generated reset
  output reg  por_r
);
  reg [4:0] cnt_r = 5'h00;

  initial por_r = 1'b1;

  always @(posedge clk)
  begin
    if (cnt_r != CYCLES[4:0])
    begin
      cnt_r <= cnt_r + 5'h01;
      por_r <= 1'b1;
    end
    else
      por_r <= 1'b0;
  end
endmodule // sac_por
